// >>> pmi_cfg.svh
// Offsets, field positions, reset values and timing for the MAC port block
`ifndef PMI_CFG_SVH
`define PMI_CFG_SVH
`define PMI_REG_MACIF 4'h0
`define PMI_REG_ANCTL 4'h1
`define PMI_REG_ANADV 4'h2
`define PMI_REG_STAT 4'h3
`define PMI_MODE_MII 2'h0
`define PMI_MODE_RMII 2'h1
`define PMI_MODE_RGMII 2'h2
`define PMI_STRAP_MII 2'h1
`define PMI_STRAP_RGMII 2'h2
`define PMI_MODE_LSB 0
`define PMI_MODE_MSB 1
`define PMI_FC_EN_BIT 2
`define PMI_SWRST_BIT 3
`define PMI_AN_EN_BIT 0
`define PMI_AN_RST_BIT 1
`define PMI_ABL_BIT 0
`define PMI_REQ_BIT 1
`define PMI_MST_BIT 2
`define PMI_FC_EN_RST 1'h1
`define PMI_AN_EN_RST 1'h1
`define PMI_REQ_RST 1'h0
`define PMI_CLK_KHZ 100000
`define PMI_MAC_KHZ 2500
`define PMI_HALF_DIV (`PMI_CLK_KHZ / (2 * `PMI_MAC_KHZ))
`define PMI_RMII_REP 10
`define PMI_STRAP_WAIT 2'h3
`endif

// >>> pmi_pkg.sv
// Types shared by the MAC port block
package pmi_pkg;
  typedef enum logic [1:0] {AN_IDLE, AN_BUSY, AN_DONE} pmi_an_state_t;
endpackage : pmi_pkg

// >>> pmi_port.sv
// MAC-side port, strap capture and negotiation control of the PHY
`timescale 1ns/1ps
`include "pmi_cfg.svh"
module pmi_port #(
  parameter int AN_CYCLES = 1000
) (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic [3:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  input wire logic ref_clock_input_i,
  input wire logic macif_strap_bit0_i,
  input wire logic macif_strap_bit1_i,
  input wire logic high_amplitude_strap_i,
  input wire logic role_pref_strap_i,
  input wire logic mac_tx_en_i,
  input wire logic mac_tx_er_i,
  input wire logic [3:0] mac_txd_i,
  output logic mac_rx_clk_o,
  output logic mac_tx_clk_o,
  output logic [3:0] mac_rxd_o,
  output logic mac_rx_dv_o,
  output logic mac_rx_er_o,
  output logic mac_rx_oe_n_o,
  input wire logic line_rx_dv_i,
  input wire logic [3:0] line_rxd_i,
  input wire logic line_rx_err_i,
  input wire logic line_carrier_i,
  input wire logic line_false_carrier_i,
  input wire logic link_up_i,
  input wire logic lp_hi_able_i,
  input wire logic lp_hi_req_i,
  input wire logic lp_master_i,
  output logic line_tx_en_o,
  output logic [3:0] line_txd_o,
  output logic line_tx_er_o,
  output logic an_busy_o,
  output logic role_master_o,
  output logic tx_amplitude_select_o
);

  localparam int HALF = `PMI_HALF_DIV;
  localparam int REP = `PMI_RMII_REP;
  localparam int SYN_W = 11;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  logic [SYN_W-1:0] syn1_reg;
  logic [SYN_W-1:0] syn2_reg;
  logic ref_prev_reg;
  wire [SYN_W-1:0] pin_raw = {ref_clock_input_i, macif_strap_bit1_i, macif_strap_bit0_i,
    high_amplitude_strap_i, role_pref_strap_i, mac_tx_en_i, mac_tx_er_i, mac_txd_i};

  // Two stages before any use
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      syn1_reg <= '0;
      syn2_reg <= '0;
      ref_prev_reg <= 1'b0;
    end else begin
      syn1_reg <= pin_raw;
      syn2_reg <= syn1_reg;
      ref_prev_reg <= syn2_reg[10];
    end
  end

  wire ref_edge = syn2_reg[10] & ~ref_prev_reg;
  wire [1:0] strap_sel = syn2_reg[9:8];
  wire strap_amp = syn2_reg[7];
  wire strap_role = syn2_reg[6];
  wire tx_en_s = syn2_reg[5];
  wire tx_er_s = syn2_reg[4];
  wire [3:0] txd_s = syn2_reg[3:0];

  ////////////////////////////////////////////////////////////////////////////
  // Register state

  logic [1:0] strap_wait_reg;
  logic [1:0] mode_reg;
  logic fc_en_reg;
  logic an_en_reg;
  logic capable_reg;
  logic pref_reg;
  logic [1:0] strap_mode_reg;
  logic abl_reg;
  logic req_reg;
  logic mst_reg;
  pmi_pkg::pmi_an_state_t an_state_reg;
  logic [31:0] an_cnt_reg;
  logic link_prev_reg;

  // Register decode
  wire load_now = (strap_wait_reg == 2'h1);
  wire wr_macif = reg_wr_i & (reg_addr_i == `PMI_REG_MACIF);
  wire wr_anctl = reg_wr_i & (reg_addr_i == `PMI_REG_ANCTL);
  wire wr_anadv = reg_wr_i & (reg_addr_i == `PMI_REG_ANADV);
  wire sw_reset = wr_macif & reg_wdata_i[`PMI_SWRST_BIT];
  wire negotiation_restart_bit_wr = wr_anctl & reg_wdata_i[`PMI_AN_RST_BIT];
  wire link_drop = link_prev_reg & ~link_up_i;
  wire an_en_now = wr_anctl ? reg_wdata_i[`PMI_AN_EN_BIT] : an_en_reg;
  wire negotiation_restart_bit = an_en_now & (negotiation_restart_bit_wr | link_drop);
  wire an_finish = (an_state_reg == pmi_pkg::AN_BUSY) && (an_cnt_reg == 32'(AN_CYCLES - 1));

  // Floating select straps read 00 and give RMII
  wire [1:0] strap_mode = (strap_sel == `PMI_STRAP_MII) ? `PMI_MODE_MII :
                          (strap_sel == `PMI_STRAP_RGMII) ? `PMI_MODE_RGMII :
                          `PMI_MODE_RMII;
  wire [1:0] wr_mode = (reg_wdata_i[`PMI_MODE_MSB:`PMI_MODE_LSB] == `PMI_MODE_MII) ?
                       `PMI_MODE_MII :
                       (reg_wdata_i[`PMI_MODE_MSB:`PMI_MODE_LSB] == `PMI_MODE_RGMII) ?
                       `PMI_MODE_RGMII : `PMI_MODE_RMII;

  // Strap wait after reset or software reset
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      strap_wait_reg <= `PMI_STRAP_WAIT;
    end else if (sw_reset) begin
      strap_wait_reg <= `PMI_STRAP_WAIT;
    end else if (strap_wait_reg != 2'h0) begin
      strap_wait_reg <= strap_wait_reg - 2'h1;
    end
  end

  // Strapped values and mode control
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mode_reg <= `PMI_MODE_RMII;
      strap_mode_reg <= `PMI_MODE_RMII;
      capable_reg <= 1'b0;
      pref_reg <= 1'b0;
      fc_en_reg <= `PMI_FC_EN_RST;
    end else if (load_now) begin
      mode_reg <= strap_mode;
      strap_mode_reg <= strap_mode;
      capable_reg <= ~strap_amp;
      pref_reg <= strap_role;
      fc_en_reg <= `PMI_FC_EN_RST;
    end else if (wr_macif & ~sw_reset) begin
      mode_reg <= wr_mode;
      fc_en_reg <= reg_wdata_i[`PMI_FC_EN_BIT];
    end
  end

  // Advertisement and forced role bits
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      an_en_reg <= `PMI_AN_EN_RST;
      abl_reg <= 1'b0;
      req_reg <= `PMI_REQ_RST;
      mst_reg <= 1'b0;
    end else if (load_now) begin
      an_en_reg <= `PMI_AN_EN_RST;
      abl_reg <= ~strap_amp;
      req_reg <= `PMI_REQ_RST;
      mst_reg <= strap_role;
    end else begin
      if (wr_anctl) begin
        an_en_reg <= reg_wdata_i[`PMI_AN_EN_BIT];
      end
      if (wr_anadv) begin
        abl_reg <= reg_wdata_i[`PMI_ABL_BIT] & capable_reg;
        req_reg <= reg_wdata_i[`PMI_REQ_BIT] & capable_reg;
      end
      if (an_finish) begin
        mst_reg <= lp_master_i;
      end else if (wr_anadv) begin
        mst_reg <= reg_wdata_i[`PMI_MST_BIT];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Negotiation sequencing

  wire hi_level = abl_reg & lp_hi_able_i & (req_reg | lp_hi_req_i);

  // Restart on link drop or restart write
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      an_state_reg <= pmi_pkg::AN_BUSY;
      an_cnt_reg <= '0;
      link_prev_reg <= 1'b0;
    end else begin
      link_prev_reg <= link_up_i;
      if (load_now) begin
        an_state_reg <= pmi_pkg::AN_BUSY;
        an_cnt_reg <= '0;
      end else if (negotiation_restart_bit) begin
        an_state_reg <= pmi_pkg::AN_BUSY;
        an_cnt_reg <= '0;
      end else if (!an_en_reg) begin
        an_state_reg <= pmi_pkg::AN_IDLE;
        an_cnt_reg <= '0;
      end else begin
        case (an_state_reg)
          pmi_pkg::AN_IDLE: begin
            an_state_reg <= pmi_pkg::AN_BUSY;
          end
          pmi_pkg::AN_BUSY: begin
            an_cnt_reg <= an_cnt_reg + 32'h1;
            if (an_finish) begin
              an_state_reg <= pmi_pkg::AN_DONE;
            end
          end
          pmi_pkg::AN_DONE: begin
            an_state_reg <= pmi_pkg::AN_DONE;
          end
          default: begin
            an_state_reg <= pmi_pkg::AN_IDLE;
          end
        endcase
      end
    end
  end

  // Role and amplitude outputs
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      an_busy_o <= 1'b0;
      role_master_o <= 1'b0;
      tx_amplitude_select_o <= 1'b0;
    end else begin
      an_busy_o <= (an_state_reg == pmi_pkg::AN_BUSY);
      role_master_o <= mst_reg;
      if (!an_en_reg) begin
        tx_amplitude_select_o <= abl_reg & req_reg;
      end else if (an_finish) begin
        tx_amplitude_select_o <= hi_level;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // 2.5 MHz divider for MII and RGMII

  logic [4:0] div_cnt_reg;
  wire div_wrap = (div_cnt_reg == 5'(HALF - 1));
  wire is_mii = (mode_reg == `PMI_MODE_MII);
  wire is_rmii = (mode_reg == `PMI_MODE_RMII);
  wire is_rgmii = (mode_reg == `PMI_MODE_RGMII);
  wire ready = (strap_wait_reg == 2'h0);
  wire tick_rise = ready & ~is_rmii & div_wrap & ~mac_rx_clk_o;
  wire tick_fall = ready & ~is_rmii & div_wrap & mac_rx_clk_o;

  // Receive and transmit clocks
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      div_cnt_reg <= 5'h0;
      mac_rx_clk_o <= 1'b0;
      mac_tx_clk_o <= 1'b0;
    end else if (!ready || is_rmii) begin
      div_cnt_reg <= 5'h0;
      mac_rx_clk_o <= 1'b0;
      mac_tx_clk_o <= 1'b0;
    end else begin
      div_cnt_reg <= div_wrap ? 5'h0 : div_cnt_reg + 5'h1;
      if (div_wrap) begin
        mac_rx_clk_o <= ~mac_rx_clk_o;
        mac_tx_clk_o <= ~mac_tx_clk_o;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // RMII dibit phase on the reference clock

  logic [4:0] rm_cnt_reg;
  logic [3:0] rm_hold_reg;
  logic rm_dv_reg;
  logic [1:0] rm_tx_lo_reg;
  wire rm_wrap = (rm_cnt_reg == 5'(2 * REP - 1));
  wire rm_step = ready & is_rmii & ref_edge;
  wire rm_first = (rm_cnt_reg == 5'h0);
  wire rm_tx_lo = (rm_cnt_reg == 5'(REP / 2));
  wire rm_tx_hi = (rm_cnt_reg == 5'(REP + REP / 2));
  wire [1:0] rm_dibit = (rm_cnt_reg < 5'(REP)) ? rm_hold_reg[1:0] : rm_hold_reg[3:2];

  // Nibble held for ten reference edges per dibit
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rm_cnt_reg <= 5'h0;
      rm_hold_reg <= 4'h0;
      rm_dv_reg <= 1'b0;
      rm_tx_lo_reg <= 2'h0;
    end else if (rm_step) begin
      rm_cnt_reg <= rm_wrap ? 5'h0 : rm_cnt_reg + 5'h1;
      if (rm_wrap) begin
        rm_hold_reg <= line_rxd_i;
        rm_dv_reg <= line_rx_dv_i;
      end
      if (rm_tx_lo) begin
        rm_tx_lo_reg <= txd_s[1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receive toward the MAC

  logic rg_dv_reg;
  logic rg_er_reg;

  // Pins driven only once straps are taken
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mac_rx_oe_n_o <= 1'b1;
    end else begin
      mac_rx_oe_n_o <= ~ready;
    end
  end

  // Per-mode receive data and control
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mac_rxd_o <= 4'h0;
      mac_rx_dv_o <= 1'b0;
      mac_rx_er_o <= 1'b0;
      rg_dv_reg <= 1'b0;
      rg_er_reg <= 1'b0;
    end else if (!ready) begin
      mac_rxd_o <= 4'h0;
      mac_rx_dv_o <= 1'b0;
      mac_rx_er_o <= 1'b0;
    end else if (is_mii & tick_fall) begin
      mac_rxd_o <= line_rxd_i;
      mac_rx_dv_o <= line_rx_dv_i;
      mac_rx_er_o <= line_rx_dv_i & line_rx_err_i;
    end else if (is_rgmii & tick_rise) begin
      mac_rxd_o <= line_rxd_i;
      mac_rx_dv_o <= line_rx_dv_i;
      rg_dv_reg <= line_rx_dv_i;
      rg_er_reg <= line_rx_err_i;
    end else if (is_rgmii & tick_fall) begin
      mac_rx_dv_o <= rg_dv_reg ^ rg_er_reg;
    end else if (is_rmii) begin
      if (rm_step) begin
        mac_rxd_o <= {2'h0, rm_first ? line_rxd_i[1:0] : rm_dibit};
        mac_rx_er_o <= line_rx_err_i | (line_false_carrier_i & fc_en_reg);
        mac_rx_dv_o <= line_carrier_i;
      end else if (ready & line_carrier_i) begin
        mac_rx_dv_o <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transmit from the MAC

  logic rg_tx_en_reg;

  // MAC nibbles passed to the line
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      line_tx_en_o <= 1'b0;
      line_txd_o <= 4'h0;
      line_tx_er_o <= 1'b0;
      rg_tx_en_reg <= 1'b0;
    end else if (is_mii & tick_rise) begin
      line_tx_en_o <= tx_en_s;
      line_txd_o <= txd_s;
      line_tx_er_o <= tx_er_s;
    end else if (is_rgmii & tick_rise) begin
      rg_tx_en_reg <= tx_en_s;
      line_txd_o <= txd_s;
    end else if (is_rgmii & tick_fall) begin
      line_tx_en_o <= rg_tx_en_reg;
      line_tx_er_o <= rg_tx_en_reg ^ tx_en_s;
    end else if (rm_step & rm_tx_hi) begin
      line_tx_en_o <= tx_en_s;
      line_txd_o <= {txd_s[1:0], rm_tx_lo_reg};
      line_tx_er_o <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register read port

  wire [31:0] rd_macif = {29'h0, fc_en_reg, mode_reg};
  wire [31:0] rd_anctl = {31'h0, an_en_reg};
  wire [31:0] rd_anadv = {29'h0, mst_reg, req_reg, abl_reg};
  wire [31:0] rd_stat = {23'h0, role_master_o, tx_amplitude_select_o,
    an_state_reg == pmi_pkg::AN_DONE, an_state_reg == pmi_pkg::AN_BUSY,
    link_up_i, strap_mode_reg, pref_reg, capable_reg};
  wire [31:0] rd_mux = (reg_addr_i == `PMI_REG_MACIF) ? rd_macif :
                       (reg_addr_i == `PMI_REG_ANCTL) ? rd_anctl :
                       (reg_addr_i == `PMI_REG_ANADV) ? rd_anadv :
                       (reg_addr_i == `PMI_REG_STAT) ? rd_stat : 32'h0;

  // Read data one cycle after the strobe
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      reg_rdata_o <= 32'h0;
    end else if (reg_rd_i) begin
      reg_rdata_o <= rd_mux;
    end else begin
      reg_rdata_o <= 32'h0;
    end
  end

endmodule : pmi_port

// >>> pmi_port_sva.sv
// Assertion checker bound to the MAC port block
`timescale 1ns/1ps
`include "pmi_cfg.svh"
module pmi_port_sva #(
  parameter int AN_CYCLES = 1000
) (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic [3:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [31:0] reg_rdata_o,
  input wire logic link_up_i,
  input wire logic lp_master_i,
  input wire logic line_carrier_i,
  input wire logic mac_rx_clk_o,
  input wire logic mac_tx_clk_o,
  input wire logic mac_rx_dv_o,
  input wire logic mac_rx_er_o,
  input wire logic mac_rx_oe_n_o,
  input wire logic an_busy_o,
  input wire logic role_master_o
);
  ////////////////////////////////////////
  // Core clock, quiet while in reset
  default clocking @(posedge clock_i);
  endclocking
  default disable iff (!rst_n_i);
  // High phase of the MAC clock lasts a full half period
  rx_clk_shape_a: assert property (
    $fell(mac_rx_clk_o) && !$past(reg_wr_i) && !$past(reg_wr_i, 2) |-> $past(mac_rx_clk_o, 20))
    else $error("receive clock high phase too short");
  // Both MAC clocks come from one divider
  tx_clk_pair_a: assert property (mac_tx_clk_o == mac_rx_clk_o)
    else $error("transmit clock differs from receive clock");
  // Read data only in the cycle after a read
  rd_data_idle_a: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 32'h0)
    else $error("read data outside the read slot");
  // Restart write starts negotiation
  negotiation_restart_bit_a: assert property (
    reg_wr_i && reg_addr_i == `PMI_REG_ANCTL && reg_wdata_i[`PMI_AN_EN_BIT]
    && reg_wdata_i[`PMI_AN_RST_BIT] |-> ##[1:2] an_busy_o)
    else $error("restart write did not start negotiation");
  // Link loss starts negotiation
  link_drop_a: assert property ($fell(link_up_i) |-> ##[1:2] an_busy_o)
    else $error("link drop did not restart negotiation");
  // Negotiation runs for a while once started
  an_hold_a: assert property ($rose(an_busy_o) |-> an_busy_o[*8])
    else $error("negotiation ended too early");
  // Completion takes the partner role
  an_role_a: assert property ($fell(an_busy_o) |-> ##[0:2] role_master_o == lp_master_i)
    else $error("role not taken from negotiation");
  // Receive pins quiet while released
  rx_quiet_a: assert property (mac_rx_oe_n_o |-> !mac_rx_dv_o && !mac_rx_er_o)
    else $error("receive pins active while released");
  // Carrier raises merged valid at once
  crs_fast_a: assert property (
    line_carrier_i && !mac_rx_oe_n_o |-> ##[1:2] mac_rx_dv_o)
    else $error("carrier did not raise merged valid");
endmodule : pmi_port_sva
bind pmi_port pmi_port_sva #(.AN_CYCLES(AN_CYCLES)) i_sva (.clock_i, .rst_n_i, .reg_addr_i,
  .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .link_up_i, .lp_master_i, .line_carrier_i,
  .mac_rx_clk_o, .mac_tx_clk_o, .mac_rx_dv_o, .mac_rx_er_o, .mac_rx_oe_n_o, .an_busy_o,
  .role_master_o);

// >>> pmi_mac_model.sv
// Behavioural MAC facing the port block
`timescale 1ns/1ps
module pmi_mac_model (
  input wire logic clock_i,
  input wire logic ref_on_i,
  input wire logic tx_clk_i,
  input wire logic rx_clk_i,
  input wire logic [3:0] rxd_i,
  input wire logic rx_dv_i,
  input wire logic rx_er_i,
  output logic ref_clk_o,
  output logic tx_en_o,
  output logic tx_er_o,
  output logic [3:0] txd_o,
  output logic [3:0] got_nib_o,
  output logic got_dv_o,
  output logic got_er_o
);
  logic [3:0] send_nib;
  logic [3:0] idle_pat;
  logic rx_clk_q;
  ////////////////////////////////////////
  // Start values
  initial begin
    tx_en_o = 1'h0;
    send_nib = 4'h0;
    idle_pat = 4'h5;
    rx_clk_q = 1'h0;
  end
  // Reference clock, still until enabled, free phase
  initial begin
    ref_clk_o = 1'h0;
    #3;
    forever #40 ref_clk_o = ref_on_i ? ~ref_clk_o : 1'h0;
  end
  // Idle data lines change every cycle
  always @(posedge clock_i) begin
    idle_pat <= ~idle_pat;
  end
  assign txd_o = tx_en_o ? send_nib : idle_pat;
  assign tx_er_o = 1'h0;
  // Receive side taken one core cycle after the rising MAC clock
  always @(posedge clock_i) begin
    rx_clk_q <= rx_clk_i;
    if (rx_clk_i && !rx_clk_q) begin
      got_nib_o <= rxd_i;
      got_dv_o <= rx_dv_i;
      got_er_o <= rx_er_i;
    end
  end
  ////////////////////////////////////////
  // One nibble launched after a falling transmit clock
  task automatic send(input logic [3:0] nib);
    @(negedge tx_clk_i);
    @(posedge clock_i);
    send_nib <= nib;
    tx_en_o <= 1'h1;
    @(negedge tx_clk_i);
    @(posedge clock_i);
    tx_en_o <= 1'h0;
  endtask : send
endmodule : pmi_mac_model

// >>> testbench.sv
// Self-checking bench for the MAC port block
`timescale 1ns/1ps
module testbench;
  logic clock_i = 1'h0, rst_n_i = 1'h0, reg_wr_i = 1'h0, reg_rd_i = 1'h0;
  logic [3:0] reg_addr_i = 4'h0, line_rxd_i = 4'h0;
  logic [31:0] reg_wdata_i = 32'h0, reg_rdata_o;
  logic macif_strap_bit0_i = 1'h0, macif_strap_bit1_i = 1'h0, high_amplitude_strap_i = 1'h0;
  logic role_pref_strap_i = 1'h0, line_rx_dv_i = 1'h0, line_rx_err_i = 1'h0;
  logic line_carrier_i = 1'h0, line_false_carrier_i = 1'h0, link_up_i = 1'h1, ref_on = 1'h0;
  logic lp_hi_able_i = 1'h1, lp_hi_req_i = 1'h1, lp_master_i = 1'h1;
  logic ref_clock_input_i, mac_tx_en_i, mac_tx_er_i, got_dv, got_er;
  logic [3:0] mac_txd_i, mac_rxd_o, line_txd_o, got_nib;
  logic mac_rx_clk_o, mac_tx_clk_o, mac_rx_dv_o, mac_rx_er_o, mac_rx_oe_n_o;
  logic line_tx_en_o, line_tx_er_o, an_busy_o, role_master_o, tx_amplitude_select_o;
  int fails = 0;
  int compares = 0;
  int cycles = 0;
  ////////////////////////////////////////
  // Design with a short negotiation time, and the MAC
  pmi_port #(.AN_CYCLES(20)) i_dut (.clock_i, .rst_n_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
    .reg_rd_i, .reg_rdata_o, .ref_clock_input_i, .macif_strap_bit0_i, .macif_strap_bit1_i,
    .high_amplitude_strap_i, .role_pref_strap_i, .mac_tx_en_i, .mac_tx_er_i, .mac_txd_i,
    .mac_rx_clk_o, .mac_tx_clk_o, .mac_rxd_o, .mac_rx_dv_o, .mac_rx_er_o, .mac_rx_oe_n_o,
    .line_rx_dv_i, .line_rxd_i, .line_rx_err_i, .line_carrier_i, .line_false_carrier_i,
    .link_up_i, .lp_hi_able_i, .lp_hi_req_i, .lp_master_i, .line_tx_en_o, .line_txd_o,
    .line_tx_er_o, .an_busy_o, .role_master_o, .tx_amplitude_select_o);
  pmi_mac_model i_mac (.clock_i, .ref_on_i(ref_on), .tx_clk_i(mac_tx_clk_o),
    .rx_clk_i(mac_rx_clk_o), .rxd_i(mac_rxd_o), .rx_dv_i(mac_rx_dv_o), .rx_er_i(mac_rx_er_o),
    .ref_clk_o(ref_clock_input_i), .tx_en_o(mac_tx_en_i), .tx_er_o(mac_tx_er_i),
    .txd_o(mac_txd_i), .got_nib_o(got_nib), .got_dv_o(got_dv), .got_er_o(got_er));
  // Core clock and hang limit
  always #5 clock_i = ~clock_i;
  always @(posedge clock_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fails = fails + 1;
      report_and_stop();
    end
  end
  ////////////////////////////////////////
  // Compare, register access and waiting helpers
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares = compares + 1;
    if (seen !== exp) begin
      fails = fails + 1;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clock_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'h1;
    @(posedge clock_i);
    reg_wr_i <= 1'h0;
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [31:0] v);
    @(posedge clock_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'h1;
    @(posedge clock_i);
    reg_rd_i <= 1'h0;
    @(posedge clock_i);
    v = reg_rdata_o;
  endtask : rd
  task automatic rdc(input logic [3:0] a, input logic [31:0] exp);
    logic [31:0] v;
    rd(a, v);
    chk(v, exp);
  endtask : rdc
  task automatic idle(input int n);
    repeat (n) @(posedge clock_i);
  endtask : idle
  task automatic wait_done;
    idle(3);
    for (int i = 0; i < 200 && an_busy_o !== 1'h0; i++) @(posedge clock_i);
  endtask : wait_done
  task automatic report_and_stop;
    $display("compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : report_and_stop
  ////////////////////////////////////////
  // Main sequence
  initial begin
    logic [31:0] v;
    repeat (3) @(posedge clock_i);
    rst_n_i <= 1'h1;
    idle(6);
    // Floating straps: register defaults
    rdc(4'h0, 32'h5);
    rdc(4'h1, 32'h1);
    rdc(4'h2, 32'h1);
    rdc(4'h9, 32'h0);
    rd(4'h3, v);
    chk(v & 32'h3, 32'h1);
    chk(mac_rx_oe_n_o, 1'h0);
    // Negotiation outcome, link drop, restart, disabled mode
    wait_done();
    chk(role_master_o, 1'h1);
    chk(tx_amplitude_select_o, 1'h1);
    link_up_i <= 1'h0;
    idle(3);
    chk(an_busy_o, 1'h1);
    link_up_i <= 1'h1;
    wait_done();
    wr(4'h1, 32'h3);
    idle(2);
    chk(an_busy_o, 1'h1);
    wait_done();
    wr(4'h1, 32'h0);
    idle(3);
    chk(tx_amplitude_select_o, 1'h0);
    wr(4'h2, 32'h3);
    idle(3);
    chk(tx_amplitude_select_o, 1'h1);
    chk(role_master_o, 1'h0);
    wr(4'h1, 32'h1);
    // New straps taken by software reset
    macif_strap_bit0_i <= 1'h1;
    high_amplitude_strap_i <= 1'h1;
    role_pref_strap_i <= 1'h1;
    wr(4'h0, 32'h8);
    idle(2);
    chk(mac_rx_oe_n_o, 1'h1);
    idle(6);
    rdc(4'h0, 32'h4);
    rdc(4'h2, 32'h4);
    rd(4'h3, v);
    chk(v & 32'h3, 32'h2);
    wr(4'h2, 32'h3);
    rdc(4'h2, 32'h0);
    // MII receive with a line error, then idle
    line_rxd_i <= 4'ha;
    line_rx_dv_i <= 1'h1;
    line_rx_err_i <= 1'h1;
    idle(90);
    chk(got_nib, 4'ha);
    chk(got_dv, 1'h1);
    chk(got_er, 1'h1);
    line_rx_dv_i <= 1'h0;
    line_rx_err_i <= 1'h0;
    idle(90);
    chk(got_dv, 1'h0);
    chk(got_er, 1'h0);
    // MII transmit of one nibble
    i_mac.send(4'h6);
    chk(line_txd_o, 4'h6);
    chk(line_tx_en_o, 1'h1);
    chk(line_tx_er_o, 1'h0);
    // RGMII receive control on both clock phases
    wr(4'h0, 32'h6);
    line_rx_dv_i <= 1'h1;
    line_rx_err_i <= 1'h1;
    idle(90);
    chk(got_dv, 1'h1);
    @(negedge mac_rx_clk_o);
    @(posedge clock_i);
    chk(mac_rx_dv_o, 1'h0);
    line_rx_dv_i <= 1'h0;
    line_rx_err_i <= 1'h0;
    // RGMII transmit control on both clock phases
    i_mac.send(4'h9);
    chk(line_txd_o, 4'h9);
    chk(line_tx_en_o, 1'h1);
    chk(line_tx_er_o, 1'h0);
    // RMII only once the reference runs
    ref_on <= 1'h1;
    idle(20);
    wr(4'h0, 32'h5);
    idle(10);
    line_carrier_i <= 1'h1;
    @(posedge clock_i);
    line_carrier_i <= 1'h0;
    idle(1);
    chk(mac_rx_dv_o, 1'h1);
    line_false_carrier_i <= 1'h1;
    idle(30);
    chk(mac_rx_er_o, 1'h1);
    chk(mac_rx_dv_o, 1'h0);
    wr(4'h0, 32'h1);
    idle(30);
    chk(mac_rx_er_o, 1'h0);
    report_and_stop();
  end
endmodule : testbench
